// >>> pkg/dtc_pkg.sv
package dtc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] COUNT_OFFSET = 12'h008;
  localparam logic [11:0] PREV_ADDR_OFFSET = 12'h00C;
  localparam logic [11:0] STACK_SEL_OFFSET = 12'h010;
  localparam logic [11:0] STACK_DATA_OFFSET = 12'h014;
  localparam logic [11:0] FORCE_OFFSET = 12'h018;
  localparam logic [11:0] BG_ADDR_OFFSET = 12'h01C;
  localparam logic [11:0] BG_DATA_OFFSET = 12'h020;
  localparam logic [11:0] BP_ACTION_OFFSET = 12'h024;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_SW_EN = 0;
  localparam int CTRL_IN_POL = 1;
  localparam int CTRL_FILT_EN = 2;
  localparam int CTRL_TRACE_EN = 3;
  localparam int CTRL_IN_HALT = 4;
  localparam int CTRL_IN_TOUT = 5;
  localparam int CTRL_OUT_POL = 6;
  localparam int CTRL_ONE_SHOT = 7;
  localparam int CTRL_SW_CLR = 8;
  localparam int CTRL_IN_COND = 9;
  localparam logic [9:0] CTRL_RESET = 10'h000;

  // breakpoint action fields: [0] halt, [1] trigger out, per source
  localparam int BPA_LINE = 0;
  localparam int BPA_DATA = 2;
  localparam int BPA_EVENT = 4;
  localparam logic [5:0] BPA_RESET = 6'h01;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ONE_SHOT_NS = 1000;
  localparam int ONE_SHOT_CYCLES = ONE_SHOT_NS / CLK_PERIOD_NS;
  localparam int FILTER_CYCLES = 4;
  localparam int SW_BP_COST = 2;

  typedef enum logic [1:0] {
    BG_IDLE = 2'b00,
    BG_WAIT = 2'b01,
    BG_DONE = 2'b11
  } dtc_bg_state_t;

endpackage : dtc_pkg

// >>> pkg/dtc_trig_if.sv
`timescale 1ns/1ps
interface dtc_trig_if;
  logic pinIn;
  logic polNeg;
  logic filtEn;
  logic pulse;
  modport owner (output pinIn, output polNeg, output filtEn, input pulse);
  modport detect (input pinIn, input polNeg, input filtEn, output pulse);
endinterface : dtc_trig_if

// >>> hdl/dtc_trigger_input_pin.sv
`timescale 1ns/1ps
module dtc_trigger_input_pin
  import dtc_pkg::*;
#(
  parameter int FILTER_LEN = FILTER_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  dtc_trig_if.detect trig
);
  typedef struct packed {
    logic syncA;
    logic syncB;
    logic level;
    logic levelDly;
    logic [7:0] stable;
  } dtc_tin_t;

  dtc_tin_t st_reg, st_next;
  logic active;

  always_comb begin
    st_next = st_reg;
    // second flop feeds everything downstream
    st_next.syncA = trig.pinIn;
    st_next.syncB = st_reg.syncA;
    active = st_reg.syncB ^ trig.polNeg;
    if (!trig.filtEn) begin
      st_next.level = active;
      st_next.stable = 8'h00;
    end else if (active == st_reg.level) begin
      st_next.stable = 8'h00;
    end else if (st_reg.stable >= 8'(FILTER_LEN - 1)) begin
      // short glitches never reach this count
      st_next.level = active;
      st_next.stable = 8'h00;
    end else begin
      st_next.stable = st_reg.stable + 8'h01;
    end
    st_next.levelDly = st_reg.level;
  end

  assign trig.pulse = st_reg.level & ~st_reg.levelDly;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end
endmodule : dtc_trigger_input_pin

// >>> hdl/dtc_debug_core.sv
`timescale 1ns/1ps
// What this block does
// R01: 32-bit stopwatch counts executed instruction cycles while running.
// R02: counts machine cycles, so multi-cycle instructions add several counts.
// R03: enabling stopwatch takes two breakpoint comparators from general use.
// R04: trigger input pulse may raise condition, halt, and/or emit trigger out.
// R05: trigger input polarity selects positive or negative going pulse.
// R06: optional filter rejects short noise on trigger input.
// R07: trace trigger enabled marks a trace capture on input pulse.
// R08: event breakpoint on trigger input halts the program.
// R09: line, data/address or event breakpoint hits emit trigger out.
// R10: each breakpoint can emit trigger out without halting.
// R11: trigger output polarity selects pulse direction from idle level.
// R12: one-shot mode gives fixed-width output pulses.
// R13: without one-shot, output lasts as long as its cause.
// R14: host force command emits one trigger output pulse.
// R15: return stack readable by level on halt, first level is zero.
// R16: keep previous instruction address for caller identification.
// R17: previous address shows whether a skip instruction skipped.
// R18: after out-of-bounds halt, previous address holds wild branch.
// R19: background port reads and writes memory while running or sleeping.
// R20: breakpoints reconfigurable at run time without halting.
// R21: event breakpoint action halts, triggers out, or both.
// R22: trigger input passes two synchronising flops before edge detection.
module dtc_debug_core
  import dtc_pkg::*;
#(
  parameter int COUNT_W = 32,
  parameter int ADDR_W = 15,
  parameter int STACK_DEPTH = 16,
  parameter int BP_TOTAL = 4,
  parameter int ONE_SHOT_LEN = ONE_SHOT_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic coreRun,
  input wire logic cycleDone,
  input wire logic instrRetire,
  input wire logic [ADDR_W-1:0] instrAddr,
  input wire logic coreHalted,
  input wire logic [ADDR_W-1:0] stackData,
  input wire logic lineHit,
  input wire logic dataHit,
  input wire logic eventHit,
  input wire logic eventOnTrigIn,
  input wire logic trigger_input_pin,
  output logic trigger_output_pin,
  output logic haltReq,
  output logic traceMark,
  output logic trigCondition,
  output logic [3:0] stackLevel,
  output logic [3:0] bpAvailable,
  output logic bgReq,
  output logic bgWrite,
  output logic [15:0] bgAddr,
  output logic [7:0] bgWdata,
  input wire logic bgAck,
  input wire logic [7:0] bgRdata
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0] ctrl;
    logic [5:0] bpAct;
    logic [COUNT_W-1:0] count;
    logic [ADDR_W-1:0] curAddr;
    logic [ADDR_W-1:0] prevAddr;
    logic [3:0] stackSel;
    logic [15:0] bgA;
    logic [7:0] bgW;
    logic [7:0] bgR;
    logic bgWr;
    dtc_bg_state_t bgState;
    logic forcePend;
    logic [15:0] shotCnt;
    logic outActive;
    logic halt;
    logic trace;
    logic cond;
    logic [31:0] rdata;
  } dtc_core_t;

  dtc_core_t st_reg, st_next;
  dtc_trig_if trig ();

  logic apbWrite, apbRead, mapped;
  logic inPulse, bpTout, bpHalt, outCause, outLevel;
  logic [31:0] rdMux;

  // ----------------------------------------------------------------
  // trigger input
  // ----------------------------------------------------------------
  assign trig.pinIn = trigger_input_pin;
  assign trig.polNeg = st_reg.ctrl[CTRL_IN_POL]; // [R05]
  assign trig.filtEn = st_reg.ctrl[CTRL_FILT_EN]; // [R06]

  dtc_trigger_input_pin #(.FILTER_LEN(FILTER_CYCLES)) u_trigger_input_pin ( // [R22]
    .clock(clock),
    .rst(rst),
    .clkEn(clkEn),
    .trig(trig)
  );
  assign inPulse = trig.pulse;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign apbWrite = psel & penable & pwrite;
  assign apbRead = psel & penable & ~pwrite;
  always_comb begin
    unique case (paddr)
      CTRL_OFFSET, STATUS_OFFSET, COUNT_OFFSET, PREV_ADDR_OFFSET,
      STACK_SEL_OFFSET, STACK_DATA_OFFSET, FORCE_OFFSET,
      BG_ADDR_OFFSET, BG_DATA_OFFSET, BP_ACTION_OFFSET: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // background accesses stall the bus until the memory side answers
  assign pready = !(psel && penable && paddr == BG_DATA_OFFSET
                    && st_reg.bgState != BG_DONE);
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // breakpoint actions
  // ----------------------------------------------------------------
  // action bits may change while the core runs; no halt needed [R20]
  always_comb begin
    bpTout = (lineHit & st_reg.bpAct[BPA_LINE + 1]) // [R09] [R10]
           | (dataHit & st_reg.bpAct[BPA_DATA + 1])
           | (eventHit & st_reg.bpAct[BPA_EVENT + 1]); // [R21]
    bpHalt = (lineHit & st_reg.bpAct[BPA_LINE])
           | (dataHit & st_reg.bpAct[BPA_DATA])
           | (eventHit & st_reg.bpAct[BPA_EVENT]); // [R21]
  end
  assign outCause = bpTout | (inPulse & st_reg.ctrl[CTRL_IN_TOUT]); // [R04]

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  // captured at the setup edge, so read data leaves the block from a flop
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFFSET: begin
        rdMux = 32'(st_reg.ctrl);
      end
      STATUS_OFFSET: begin
        rdMux = {27'h0, st_reg.bgState == BG_WAIT, st_reg.forcePend,
                 st_reg.outActive, coreHalted, coreRun};
      end
      COUNT_OFFSET: begin
        rdMux = 32'(st_reg.count);
      end
      PREV_ADDR_OFFSET: begin
        rdMux = 32'(st_reg.prevAddr);
      end
      STACK_SEL_OFFSET: begin
        rdMux = 32'(st_reg.stackSel);
      end
      // level 0 is the first entry; only meaningful while halted
      STACK_DATA_OFFSET: begin
        rdMux = coreHalted ? 32'(stackData) : 32'h0000_0000; // [R15]
      end
      BG_ADDR_OFFSET: begin
        rdMux = 32'(st_reg.bgA);
      end
      BG_DATA_OFFSET: begin
        rdMux = 32'(st_reg.bgR);
      end
      BP_ACTION_OFFSET: begin
        rdMux = 32'(st_reg.bpAct);
      end
      default: begin
        rdMux = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.halt = 1'b0;
    st_next.trace = 1'b0;
    st_next.cond = 1'b0;
    st_next.ctrl[CTRL_SW_CLR] = 1'b0;

    // --------------------------------------------------------------
    // stopwatch
    // --------------------------------------------------------------
    // stopwatch ticks per machine cycle, not per instruction
    if (st_reg.ctrl[CTRL_SW_CLR]) begin
      st_next.count = '0;
    end else if (st_reg.ctrl[CTRL_SW_EN] && coreRun && cycleDone) begin // [R01] [R02]
      st_next.count = st_reg.count + 1'b1;
    end

    // --------------------------------------------------------------
    // previous instruction address
    // --------------------------------------------------------------
    // previous address only moves on a retired instruction
    if (instrRetire) begin // [R16] [R17] [R18]
      st_next.prevAddr = st_reg.curAddr;
      st_next.curAddr = instrAddr;
    end

    // --------------------------------------------------------------
    // trigger input actions
    // --------------------------------------------------------------
    if (inPulse) begin
      st_next.cond = st_reg.ctrl[CTRL_IN_COND]; // [R04]
      st_next.trace = st_reg.ctrl[CTRL_TRACE_EN]; // [R07]
      st_next.halt = st_reg.ctrl[CTRL_IN_HALT] | eventOnTrigIn; // [R04] [R08]
    end
    // --------------------------------------------------------------
    // breakpoint halt
    // --------------------------------------------------------------
    if (bpHalt) begin
      st_next.halt = 1'b1;
    end

    // --------------------------------------------------------------
    // trigger output pulse
    // --------------------------------------------------------------
    // output pulse: one-shot counter or follow the cause
    if (st_reg.ctrl[CTRL_ONE_SHOT]) begin // [R12]
      if ((outCause || st_reg.forcePend) && st_reg.shotCnt == 16'h0000) begin
        st_next.shotCnt = 16'(ONE_SHOT_LEN);
        st_next.forcePend = 1'b0; // [R14]
      end else if (st_reg.shotCnt != 16'h0000) begin
        st_next.shotCnt = st_reg.shotCnt - 16'h0001;
      end
      st_next.outActive = (st_next.shotCnt != 16'h0000);
    end else begin
      // forced pulse is one cycle when the output follows its cause
      st_next.outActive = outCause | st_reg.forcePend; // [R13] [R14]
      st_next.forcePend = 1'b0;
      st_next.shotCnt = 16'h0000;
    end

    // --------------------------------------------------------------
    // background port
    // --------------------------------------------------------------
    unique case (st_reg.bgState)
      BG_IDLE: begin
        if (psel && !penable && paddr == BG_DATA_OFFSET) begin // [R19]
          st_next.bgWr = pwrite;
          if (pwrite) begin
            st_next.bgW = pwdata[7:0];
          end
          st_next.bgState = BG_WAIT;
        end
      end
      BG_WAIT: begin
        if (bgAck) begin
          st_next.bgR = bgRdata;
          st_next.bgState = BG_DONE;
        end
      end
      BG_DONE: begin
        st_next.bgState = BG_IDLE;
      end
      default: st_next.bgState = BG_IDLE;
    endcase

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------
    if (apbWrite && mapped) begin
      unique case (paddr)
        CTRL_OFFSET: begin
          st_next.ctrl = pwdata[9:0];
        end
        STACK_SEL_OFFSET: begin
          st_next.stackSel = pwdata[3:0];
        end
        BG_ADDR_OFFSET: begin
          st_next.bgA = pwdata[15:0];
        end
        BP_ACTION_OFFSET: begin
          st_next.bpAct = pwdata[5:0]; // [R20]
        end
        // a new force wins over a one-shot start that clears it in the same cycle
        FORCE_OFFSET: begin
          st_next.forcePend = st_next.forcePend | pwdata[0]; // [R14]
        end
        default: begin
          st_next.ctrl = st_next.ctrl;
        end
      endcase
    end

    // --------------------------------------------------------------
    // register read capture
    // --------------------------------------------------------------
    st_next.rdata = rdMux;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign outLevel = st_reg.outActive;
  assign trigger_output_pin = outLevel ^ st_reg.ctrl[CTRL_OUT_POL]; // [R11]
  assign haltReq = st_reg.halt;
  assign traceMark = st_reg.trace;
  assign trigCondition = st_reg.cond;
  assign stackLevel = st_reg.stackSel;
  // two comparators belong to the stopwatch while it is enabled
  assign bpAvailable = st_reg.ctrl[CTRL_SW_EN] ? 4'(BP_TOTAL - SW_BP_COST) // [R03]
                                               : 4'(BP_TOTAL);

  // ----------------------------------------------------------------
  // background port outputs
  // ----------------------------------------------------------------
  assign bgReq = (st_reg.bgState == BG_WAIT);
  assign bgWrite = st_reg.bgWr;
  assign bgAddr = st_reg.bgA;
  assign bgWdata = st_reg.bgW;

  // ----------------------------------------------------------------
  // register read data
  // ----------------------------------------------------------------
  // background data lands late in the access, so it bypasses the setup capture
  assign prdata = (paddr == BG_DATA_OFFSET) ? 32'(st_reg.bgR) : st_reg.rdata;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '{ctrl: CTRL_RESET, bpAct: BPA_RESET, bgState: BG_IDLE, default: '0};
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end
endmodule : dtc_debug_core

// >>> verif/dtc_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host debug side: background memory and return stack
// ----------------------------------------
module dtc_host_model #(
  parameter int ACK_DELAY = 3
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic bgReq,
  input wire logic bgWrite,
  input wire logic [15:0] bgAddr,
  input wire logic [7:0] bgWdata,
  output logic bgAck,
  output logic [7:0] bgRdata,
  input wire logic [3:0] stackLevel,
  output logic [14:0] stackData
);
  logic [7:0] mem [256];
  int waitCnt;
  assign stackData = 15'h0100 + 15'(stackLevel);
  // read data is only valid beside the ack; it holds while a request waits and toggles otherwise, so stale use shows up
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bgAck <= 1'b0;
      waitCnt <= 0;
      bgRdata <= 8'h00;
    end else if (bgAck) begin
      bgAck <= 1'b0;
      bgRdata <= ~bgRdata;
    end else if (bgReq && waitCnt == ACK_DELAY) begin
      bgAck <= 1'b1;
      waitCnt <= 0;
      if (bgWrite) begin
        mem[bgAddr[7:0]] <= bgWdata;
      end
      bgRdata <= mem[bgAddr[7:0]];
    end else if (bgReq) begin
      waitCnt <= waitCnt + 1;
    end else begin
      bgRdata <= ~bgRdata;
    end
  end
endmodule : dtc_host_model

// >>> verif/dtc_debug_checker.sv
`timescale 1ns/1ps
module dtc_debug_checker
  import dtc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic traceMark,
  input wire logic trigCondition,
  input wire logic trigger_output_pin,
  input wire logic [3:0] stackLevel,
  input wire logic [3:0] bpAvailable,
  input wire logic bgReq,
  input wire logic bgAck,
  input wire logic [15:0] bgAddr
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence setupPh;
    psel && !penable;
  endsequence
  sequence writeDone;
    psel && penable && pready && pwrite;
  endsequence
  stack_sel_a: assert property (writeDone ##0 (paddr == STACK_SEL_OFFSET)
    |=> stackLevel == 4'($past(pwdata))) else $error("stack level not taken");
  unmapped_a: assert property (psel && penable && paddr > 12'h024
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
  pready_a: assert property (!pready |-> psel && paddr == BG_DATA_OFFSET)
    else $error("wait state outside background access");
  bg_start_a: assert property (setupPh ##0 (paddr == BG_DATA_OFFSET)
    |=> ##[0:2] bgReq) else $error("background request missing");
  bg_hold_a: assert property (bgReq && !bgAck |=> bgReq && $stable(bgAddr))
    else $error("background request dropped early");
  trace_pulse_a: assert property ($rose(traceMark) |=> !traceMark)
    else $error("trace mark longer than one cycle");
  cond_pulse_a: assert property (trigCondition |=> $fell(trigCondition))
    else $error("condition longer than one cycle");
  bp_avail_a: assert property (bpAvailable == 4'h4 || bpAvailable == 4'h2)
    else $error("breakpoint count wrong");
  force_out_a: assert property (writeDone ##0 (paddr == FORCE_OFFSET && pwdata[0])
    |-> ##[1:3] $changed(trigger_output_pin)) else $error("forced pulse missing");
endmodule : dtc_debug_checker

bind dtc_debug_core dtc_debug_checker chk_u (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .traceMark(traceMark), .trigCondition(trigCondition),
  .trigger_output_pin(trigger_output_pin), .stackLevel(stackLevel),
  .bpAvailable(bpAvailable), .bgReq(bgReq), .bgAck(bgAck), .bgAddr(bgAddr));

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  import dtc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, trigOut, haltReq, traceMark, trigCondition, bgReq, bgWrite, bgAck;
  logic coreRun = 1'b0, cycleDone = 1'b0, instrRetire = 1'b0, coreHalted = 1'b0;
  logic lineHit = 1'b0, dataHit = 1'b0, eventHit = 1'b0, eventOnTrigIn = 1'b0, pinIn = 1'b0;
  logic idleLvl = 1'b0;
  logic [14:0] instrAddr = 15'h0000;
  logic [14:0] stackData;
  logic [3:0] stackLevel, bpAvailable;
  logic [15:0] bgAddr;
  logic [7:0] bgWdata, bgRdata;
  logic [7:0] pat [2] = '{8'hA5, 8'h3C};
  int failCount = 0, checked = 0, haltCnt = 0, traceCnt = 0, condCnt = 0, outCnt = 0;
  int ob, hb, tcb, cb;
  always #5 clock = ~clock;
  always @(posedge clock) begin
    haltCnt <= haltCnt + int'(haltReq === 1'b1);
    traceCnt <= traceCnt + int'(traceMark === 1'b1);
    condCnt <= condCnt + int'(trigCondition === 1'b1);
    outCnt <= outCnt + int'(trigOut !== idleLvl);
  end
  dtc_debug_core #(.ONE_SHOT_LEN(20)) dut_u (.clock(clock), .rst(rst), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .coreRun(coreRun),
    .cycleDone(cycleDone), .instrRetire(instrRetire), .instrAddr(instrAddr),
    .coreHalted(coreHalted), .stackData(stackData), .lineHit(lineHit), .dataHit(dataHit),
    .eventHit(eventHit), .eventOnTrigIn(eventOnTrigIn), .trigger_input_pin(pinIn),
    .trigger_output_pin(trigOut), .haltReq(haltReq), .traceMark(traceMark),
    .trigCondition(trigCondition), .stackLevel(stackLevel), .bpAvailable(bpAvailable),
    .bgReq(bgReq), .bgWrite(bgWrite), .bgAddr(bgAddr), .bgWdata(bgWdata), .bgAck(bgAck),
    .bgRdata(bgRdata));
  dtc_host_model host_u (.clock(clock), .rst(rst), .bgReq(bgReq), .bgWrite(bgWrite),
    .bgAddr(bgAddr), .bgWdata(bgWdata), .bgAck(bgAck), .bgRdata(bgRdata),
    .stackLevel(stackLevel), .stackData(stackData));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // called just after a rising edge; one idle cycle follows every transfer
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    if (n >= 500) failCount++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task pinPulse(input logic lvl, input int len);
    @(posedge clock);
    pinIn <= lvl;
    repeat (len) @(posedge clock);
    pinIn <= ~lvl;
    repeat (15) @(posedge clock);
  endtask : pinPulse
  task print_verdict;
    if (failCount == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clock);
    failCount++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    apb(1'b0, BP_ACTION_OFFSET, 32'h0);
    check(rd, 32'h01);
    check(32'(bpAvailable), 32'h4);
    apb(1'b0, 12'h0FC, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    check(32'(bpAvailable), 32'h2);
    coreRun <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      cycleDone <= 1'b1;
      instrRetire <= (i % 3 == 0);
      instrAddr <= 15'h0200 + 15'(i);
    end
    @(posedge clock);
    cycleDone <= 1'b0;
    instrRetire <= 1'b0;
    apb(1'b0, COUNT_OFFSET, 32'h0);
    check(rd, 32'h7);
    apb(1'b0, PREV_ADDR_OFFSET, 32'h0);
    check(rd, 32'h203);
    clkEn <= 1'b0;
    cycleDone <= 1'b1;
    repeat (3) @(posedge clock);
    clkEn <= 1'b1;
    cycleDone <= 1'b0;
    apb(1'b0, COUNT_OFFSET, 32'h0);
    check(rd, 32'h7);
    apb(1'b1, BP_ACTION_OFFSET, 32'h2A);
    apb(1'b0, BP_ACTION_OFFSET, 32'h0);
    check(rd, 32'h2A);
    hb = haltCnt;
    for (int s = 0; s < 3; s++) begin
      ob = outCnt;
      {eventHit, dataHit, lineHit} <= 3'(1 << s);
      repeat (5) @(posedge clock);
      {eventHit, dataHit, lineHit} <= 3'b000;
      repeat (5) @(posedge clock);
      check(32'(outCnt - ob), 32'h5);
    end
    check(32'(haltCnt - hb), 32'h0);
    ob = outCnt;
    apb(1'b1, FORCE_OFFSET, 32'h1);
    repeat (4) @(posedge clock);
    check(32'(outCnt - ob), 32'h1);
    apb(1'b1, CTRL_OFFSET, 32'hC0);
    idleLvl <= 1'b1;
    repeat (3) @(posedge clock);
    check(32'(trigOut), 32'h1);
    ob = outCnt;
    lineHit <= 1'b1;
    @(posedge clock);
    lineHit <= 1'b0;
    repeat (30) @(posedge clock);
    check(32'(outCnt - ob), 32'd20);
    apb(1'b1, CTRL_OFFSET, 32'h21C);
    idleLvl <= 1'b0;
    eventOnTrigIn <= 1'b1;
    hb = haltCnt;
    tcb = traceCnt;
    cb = condCnt;
    pinPulse(1'b1, 10);
    check(32'(haltCnt - hb), 32'h1);
    check(32'(traceCnt - tcb), 32'h1);
    check(32'(condCnt - cb), 32'h1);
    pinPulse(1'b1, 1);
    check(32'(haltCnt - hb), 32'h1);
    pinIn <= 1'b1;
    repeat (10) @(posedge clock);
    apb(1'b1, CTRL_OFFSET, 32'h36);
    hb = haltCnt;
    tcb = traceCnt;
    ob = outCnt;
    pinPulse(1'b0, 10);
    check(32'(haltCnt - hb), 32'h1);
    check(32'(traceCnt - tcb), 32'h0);
    check(32'(outCnt - ob), 32'h1);
    coreRun <= 1'b0;
    coreHalted <= 1'b1;
    for (int l = 0; l < 16; l += 15) begin
      apb(1'b1, STACK_SEL_OFFSET, 32'(l));
      check(32'(stackLevel), 32'(l));
      apb(1'b0, STACK_DATA_OFFSET, 32'h0);
      check(rd, 32'h100 + 32'(l));
    end
    coreHalted <= 1'b0;
    coreRun <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, BG_ADDR_OFFSET, 32'h12 + 32'(i));
      apb(1'b1, BG_DATA_OFFSET, 32'(pat[i]));
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, BG_ADDR_OFFSET, 32'h12 + 32'(i));
      apb(1'b0, BG_DATA_OFFSET, 32'h0);
      check(rd, 32'(pat[i]));
    end
    print_verdict();
  end
endmodule : tb
